// [design/pwm_pkg.sv]
// Purpose: Shared constants and types for the single-slope waveform counter
// Assumes: One 20 MHz clock, registers on AHB-Lite, 32-bit word per register
// Notes: Offsets are byte addresses
package pwm_pkg;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] TOP_8BIT = 16'h00FF;
   localparam logic [15:0] TOP_9BIT = 16'h01FF;
   localparam logic [15:0] TOP_10BIT = 16'h03FF;
   localparam logic [3:0] MODE_CTC_A = 4'h4;
   localparam logic [3:0] MODE_FAST_8 = 4'h5;
   localparam logic [3:0] MODE_FAST_9 = 4'h6;
   localparam logic [3:0] MODE_FAST_10 = 4'h7;
   localparam logic [3:0] MODE_CTC_CAP = 4'hC;
   localparam logic [3:0] MODE_FAST_CAP = 4'hE;
   localparam logic [3:0] MODE_FAST_A = 4'hF;
   localparam logic [1:0] OUT_OFF = 2'h0;
   localparam logic [1:0] OUT_TOGGLE = 2'h1;
   localparam logic [1:0] OUT_CLR_MATCH = 2'h2;
   localparam logic [1:0] OUT_SET_MATCH = 2'h3;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_COUNT = 8'h04;
   localparam logic [7:0] OFS_CMP_A = 8'h08;
   localparam logic [7:0] OFS_CMP_B = 8'h0C;
   localparam logic [7:0] OFS_CAPT = 8'h10;
   localparam logic [7:0] OFS_FLAGS = 8'h14;
   localparam logic [7:0] OFS_PRESC = 8'h18;
   // Control field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_OMA_LSB = 4;
   localparam int CTRL_OMB_LSB = 6;
   localparam int CTRL_DIRA_BIT = 8;
   localparam int CTRL_DIRB_BIT = 9;
   localparam logic [9:0] CTRL_RESET = 10'h000;
   localparam logic [2:0] PRESC_RESET = 3'h0;
   // Prescale division, select 1..5 = 1,8,64,256,1024; 0 stops the timer
   localparam logic [10:0] DIV_1 = 11'h001;
   localparam logic [10:0] DIV_8 = 11'h008;
   localparam logic [10:0] DIV_64 = 11'h040;
   localparam logic [10:0] DIV_256 = 11'h100;
   localparam logic [10:0] DIV_1024 = 11'h400;
   typedef struct packed {
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [7:0] haddr;
   } ahb_req_t;
   typedef struct packed {
      logic [1:0] out_val;
      logic [1:0] out_en;
   } pin_drive_t;
endpackage

// [design/ctc_fast_pwm.sv]
// Purpose: 16-bit clear-on-match and fast PWM waveform counter, AHB-Lite slave
// Assumes: AHB-Lite single word transfers, zero wait states, always OKAY
// Notes: Two compare channels A and B; flags cleared by writing one
//
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module ctc_fast_pwm
   import pwm_pkg::*;
(
   input wire logic CLK_I, // 20 MHz I/O clock
   input wire logic RST_I, // Async reset, active high
   input wire logic HSEL_I, // Slave select
   input wire logic [7:0] HADDR_I, // Byte address
   input wire logic [1:0] HTRANS_I, // Transfer type
   input wire logic HWRITE_I, // Write when high
   input wire logic [2:0] HSIZE_I, // Transfer size
   input wire logic [31:0] HWDATA_I, // Write data
   input wire logic HREADY_I, // Bus ready
   output logic [31:0] HRDATA_O, // Read data
   output logic HREADYOUT_O, // Slave ready
   output logic HRESP_O, // Always OKAY
   input wire logic [1:0] PORT_VAL_I, // Port value when not overridden
   output pwm_pkg::pin_drive_t PIN_O // Pin level and enable, A in bit 0
);
   import pwm_pkg::*;

   logic [9:0] ctrl_reg;
   logic [2:0] presc_reg;
   logic [15:0] count_reg, count_next;
   logic [15:0] cmp_a_reg, cmp_a_buf_reg, cmp_b_reg, cmp_b_buf_reg, capt_reg;
   logic [3:0] flags_reg; // 0 ovf, 1 cmp A, 2 cmp B, 3 capture
   logic [1:0] wave_reg;
   logic block_reg;
   logic [10:0] presc_cnt_reg;
   ahb_req_t req_reg;
   logic wr_pend_reg;

   // Bus decode
   wire logic addr_valid = HSEL_I & HREADY_I & HTRANS_I[1];
   wire logic wr_now = wr_pend_reg;
   wire logic wr_ctrl = wr_now & (req_reg.haddr == OFS_CTRL);
   wire logic wr_count = wr_now & (req_reg.haddr == OFS_COUNT);
   wire logic wr_cmp_a = wr_now & (req_reg.haddr == OFS_CMP_A);
   wire logic wr_cmp_b = wr_now & (req_reg.haddr == OFS_CMP_B);
   wire logic wr_capt = wr_now & (req_reg.haddr == OFS_CAPT);
   wire logic wr_flags = wr_now & (req_reg.haddr == OFS_FLAGS);
   wire logic wr_presc = wr_now & (req_reg.haddr == OFS_PRESC);

   wire logic [3:0] mode = ctrl_reg[CTRL_MODE_LSB +: 4];
   wire logic [1:0] om_a = ctrl_reg[CTRL_OMA_LSB +: 2];
   wire logic [1:0] om_b = ctrl_reg[CTRL_OMB_LSB +: 2];
   wire logic [1:0] dir = {ctrl_reg[CTRL_DIRB_BIT], ctrl_reg[CTRL_DIRA_BIT]};

   wire logic is_ctc = (mode == MODE_CTC_A) | (mode == MODE_CTC_CAP);
   wire logic is_fast = (mode == MODE_FAST_8) | (mode == MODE_FAST_9)
      | (mode == MODE_FAST_10) | (mode == MODE_FAST_CAP) | (mode == MODE_FAST_A);
   wire logic top_cap = (mode == MODE_CTC_CAP) | (mode == MODE_FAST_CAP);
   wire logic top_a = (mode == MODE_CTC_A) | (mode == MODE_FAST_A);

   // TOP selection; capture TOP is live, never buffered
   logic [15:0] top;
   always_comb begin
      unique case (mode)
         MODE_FAST_8: top = TOP_8BIT;
         MODE_FAST_9: top = TOP_9BIT;
         MODE_FAST_10: top = TOP_10BIT;
         MODE_CTC_A, MODE_FAST_A: top = cmp_a_reg;
         MODE_CTC_CAP, MODE_FAST_CAP: top = capt_reg;
         default: top = CNT_MAX;
      endcase
   end
   // Resolution mask for fixed TOP modes
   wire logic fixed_top = (mode == MODE_FAST_8) | (mode == MODE_FAST_9) | (mode == MODE_FAST_10);
   wire logic [15:0] wmask = fixed_top ? top : CNT_MAX;
   wire logic [15:0] wdata_m = HWDATA_I[15:0] & wmask;

   // Prescaler: tick once per N I/O clocks
   logic [10:0] div;
   always_comb begin
      unique case (presc_reg)
         3'h1: div = DIV_1;
         3'h2: div = DIV_8;
         3'h3: div = DIV_64;
         3'h4: div = DIV_256;
         3'h5: div = DIV_1024;
         default: div = 11'h000;
      endcase
   end
   wire logic tick = (div != 11'h000) & (presc_cnt_reg == div - 11'h001);

   wire logic at_top = (is_ctc | is_fast) & (count_reg == top);
   wire logic at_max = count_reg == CNT_MAX;
   // Matches are masked in the tick after a counter write
   wire logic match_a = (count_reg == cmp_a_reg) & ~block_reg;
   wire logic match_b = (count_reg == cmp_b_reg) & ~block_reg;
   wire logic top_hit = at_top & ~block_reg;
   wire logic wrap = top_hit | at_max;

   always_comb begin
      count_next = count_reg;
      if (wr_count) begin
         count_next = HWDATA_I[15:0];
      end else if (tick) begin
         count_next = wrap ? CNT_ZERO : count_reg + 16'h0001;
      end
   end

   // Waveform state per channel
   logic [1:0] wave_next;
   wire logic [1:0] om [2];
   wire logic [1:0] mt = {match_b, match_a};
   wire logic [1:0] pin_val;
   wire logic [1:0] pin_en;
   assign om[0] = om_a;
   assign om[1] = om_b;
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_wave
         always_comb begin
            wave_next[g] = wave_reg[g];
            if (tick && om[g] != OUT_OFF) begin
               if (is_fast && om[g] != OUT_TOGGLE) begin
                  // 0x2 clears on match, 0x3 sets; opposite at wrap
                  if (mt[g]) begin
                     wave_next[g] = (om[g] == OUT_SET_MATCH);
                  end else if (wrap) begin
                     wave_next[g] = (om[g] == OUT_CLR_MATCH);
                  end
               end else if (om[g] == OUT_TOGGLE && mt[g] && (g == 0 || !is_fast)) begin
                  wave_next[g] = ~wave_reg[g];
               end
            end
         end
         // Port override only with nonzero mode, drive only when output
         assign pin_val[g] = (om[g] != OUT_OFF) ? wave_reg[g] : PORT_VAL_I[g];
         assign pin_en[g] = dir[g];
      end
   endgenerate
   assign PIN_O = '{out_val: pin_val, out_en: pin_en};

   wire logic [3:0] flag_set = {4{tick}} & {
      top_cap & top_hit,
      match_b & (is_fast | is_ctc),
      (match_a & (is_fast | is_ctc)) | (top_a & top_hit),
      (is_fast & top_hit) | at_max};

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         req_reg <= '0;
         wr_pend_reg <= 1'b0;
      end else begin
         if (HREADY_I) begin
            req_reg <= {HTRANS_I, HWRITE_I, HSIZE_I, HADDR_I};
            wr_pend_reg <= addr_valid & HWRITE_I;
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ctrl_reg <= CTRL_RESET;
         presc_reg <= PRESC_RESET;
         presc_cnt_reg <= 11'h000;
         count_reg <= CNT_ZERO;
         block_reg <= 1'b0;
         capt_reg <= CNT_ZERO;
         wave_reg <= 2'b00;
      end else begin
         if (wr_ctrl) ctrl_reg <= HWDATA_I[9:0];
         if (wr_presc) presc_reg <= HWDATA_I[2:0];
         // Restart on a new select so a stale count cannot delay the first tick
         presc_cnt_reg <= (tick || wr_presc) ? 11'h000 : presc_cnt_reg + 11'h001;
         count_reg <= count_next;
         // Held until the next tick is spent, even when stopped
         if (wr_count) block_reg <= 1'b1;
         else if (tick) block_reg <= 1'b0;
         if (wr_capt) capt_reg <= HWDATA_I[15:0];
         wave_reg <= wave_next;
      end
   end

   // Compare registers: direct outside PWM, buffered in fast PWM
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cmp_a_reg <= CNT_ZERO;
         cmp_a_buf_reg <= CNT_ZERO;
         cmp_b_reg <= CNT_ZERO;
         cmp_b_buf_reg <= CNT_ZERO;
      end else begin
         if (wr_cmp_a) cmp_a_buf_reg <= wdata_m;
         if (wr_cmp_b) cmp_b_buf_reg <= wdata_m;
         if (!is_fast) begin
            if (wr_cmp_a) cmp_a_reg <= wdata_m;
            if (wr_cmp_b) cmp_b_reg <= wdata_m;
         end else if (tick && top_hit) begin
            cmp_a_reg <= cmp_a_buf_reg;
            cmp_b_reg <= cmp_b_buf_reg;
         end
      end
   end

   // Set beats a same-cycle write-one clear
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         flags_reg <= 4'h0;
      end else begin
         flags_reg <= (flags_reg & ~(wr_flags ? HWDATA_I[3:0] : 4'h0)) | flag_set;
      end
   end

   // Read mux, unmapped offsets read zero
   logic [31:0] rdata;
   always_comb begin
      unique case (HADDR_I)
         OFS_CTRL: rdata = {22'h0, ctrl_reg};
         OFS_COUNT: rdata = {16'h0, count_reg};
         OFS_CMP_A: rdata = {16'h0, is_fast ? cmp_a_buf_reg : cmp_a_reg};
         OFS_CMP_B: rdata = {16'h0, is_fast ? cmp_b_buf_reg : cmp_b_reg};
         OFS_CAPT: rdata = {16'h0, capt_reg};
         OFS_FLAGS: rdata = {28'h0, flags_reg};
         OFS_PRESC: rdata = {29'h0, presc_reg};
         default: rdata = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) HRDATA_O <= 32'h0000_0000;
      else if (addr_valid && !HWRITE_I) HRDATA_O <= rdata;
   end
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O = 1'b0;

   property p_top_clear;
      @(posedge CLK_I) disable iff (RST_I)
         (tick && top_hit && !wr_count) |=> (count_reg == CNT_ZERO);
   endproperty
   a_top_clear: assert property (p_top_clear) else $error("counter not cleared at TOP");

   property p_top_flag;
      @(posedge CLK_I) disable iff (RST_I)
         (tick && top_hit && top_a && (is_ctc || is_fast)) |=> flags_reg[1];
   endproperty
   a_top_flag: assert property (p_top_flag) else $error("compare A flag missing at TOP");

   property p_toggle;
      @(posedge CLK_I) disable iff (RST_I)
         (tick && is_ctc && om_a == OUT_TOGGLE && match_a) |=> (wave_reg[0] != $past(wave_reg[0]));
   endproperty
   a_toggle: assert property (p_toggle) else $error("output A did not toggle");

   property p_ovf;
      @(posedge CLK_I) disable iff (RST_I)
         (tick && at_max) |=> flags_reg[0];
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow flag missing at wrap");

   property p_fast_set;
      @(posedge CLK_I) disable iff (RST_I)
         (tick && is_fast && om_a == OUT_CLR_MATCH && wrap && !match_a) |=> wave_reg[0];
   endproperty
   a_fast_set: assert property (p_fast_set) else $error("output not set at wrap");

   property p_buf_load;
      @(posedge CLK_I) disable iff (RST_I)
         (tick && is_fast && top_hit) |=> (cmp_a_reg == $past(cmp_a_buf_reg));
   endproperty
   a_buf_load: assert property (p_buf_load) else $error("buffer not loaded at TOP");

   property p_block;
      @(posedge CLK_I) disable iff (RST_I)
         (tick && block_reg && !at_max && count_reg == cmp_a_reg)
            |=> (wave_reg[0] == $past(wave_reg[0]));
   endproperty
   a_block: assert property (p_block) else $error("match not blocked after write");

   property p_hold;
      @(posedge CLK_I) disable iff (RST_I)
         (!tick) |=> (count_reg == $past(count_reg)) || $past(wr_count);
   endproperty
   a_hold: assert property (p_hold) else $error("counter moved without tick");

   property p_pin;
      @(posedge CLK_I) disable iff (RST_I)
         PIN_O.out_en == {ctrl_reg[CTRL_DIRB_BIT], ctrl_reg[CTRL_DIRA_BIT]};
   endproperty
   a_pin: assert property (p_pin) else $error("pin enable not from direction bit");
endmodule

// [test/pin_pad_model.sv]
// Purpose: Pad model for the two waveform pins, pulled up when undriven
// Assumes: Pin drive struct from the block, bit 0 channel A, bit 1 channel B
// Notes: A lost enable shows as a stuck high pad, never as a held level
`timescale 1ns/1ns
module pin_pad_model
   import pwm_pkg::*;
(
   input wire pwm_pkg::pin_drive_t PIN_I, // Drive from the block
   output logic [1:0] PAD_O // Resolved pad level
);
   // Undriven pad reads the pull-up, not the last level
   assign PAD_O = (PIN_I.out_en & PIN_I.out_val) | ~PIN_I.out_en;
endmodule

// [test/ctc_fast_pwm_tb_top.sv]
// Purpose: Self-checking bench for the waveform counter over AHB-Lite
// Assumes: Zero wait state slave, pins seen through the pad model
// Notes: Waveforms are timed from pad edges, so phase after setup is free
`timescale 1ns/1ns
module ctc_fast_pwm_tb_top;
   import pwm_pkg::*;
   typedef struct {
      logic [3:0] mode;
      logic [15:0] capt;
      logic [15:0] cmpa;
      logic [15:0] cmpb;
      logic [1:0] om;
      logic ch;
      logic [2:0] presc;
      logic [15:0] exp_h;
      logic [15:0] exp_p;
   } row_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [1:0] port_val = 2'h2;
   logic [31:0] hrdata;
   logic hready;
   logic hresp;
   pin_drive_t pin;
   logic [1:0] pad;
   logic [31:0] rd;
   int n_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   row_t rows [10];
   ctc_fast_pwm dut (
      .CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
      .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
      .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .PORT_VAL_I(port_val),
      .PIN_O(pin)
   );
   pin_pad_model u_pad (.PIN_I(pin), .PAD_O(pad));
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_errors = n_errors + 1;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Hold each phase until hready is sampled high; read data taken at that edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do begin
         @(posedge clk);
      end while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(posedge clk);
      end while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rdr(input logic [7:0] a);
      bus(1'b0, a, 32'h0000_0000);
   endtask
   task automatic wait_lvl(input logic ch, input logic lvl);
      do begin
         @(negedge clk);
      end while (pad[ch] !== lvl);
   endtask
   // Stopped, plain mode while loading, so compare writes land directly
   task automatic setup(input row_t r);
      wr(OFS_PRESC, 32'h0000_0000);
      wr(OFS_CTRL, 32'h0000_0300);
      wr(OFS_COUNT, 32'h0000_0000);
      wr(OFS_CMP_A, {16'h0000, r.cmpa});
      wr(OFS_CMP_B, {16'h0000, r.cmpb});
      wr(OFS_CAPT, {16'h0000, r.capt});
      wr(OFS_CTRL, {22'h00_0000, 2'b11, r.ch ? {r.om, 2'b00} : {2'b00, r.om}, r.mode});
      wr(OFS_PRESC, {29'h0000_0000, r.presc});
   endtask
   // Two warm-up periods let a new TOP settle before timing
   task automatic measure(input logic ch, output int h, output int p);
      int t0;
      repeat (2) begin
         wait_lvl(ch, 1'b0);
         wait_lvl(ch, 1'b1);
      end
      t0 = cyc;
      wait_lvl(ch, 1'b0);
      h = cyc - t0;
      wait_lvl(ch, 1'b1);
      p = cyc - t0;
   endtask
   initial begin
      int h;
      int p;
      logic [31:0] fexp [2];
      rows[0] = '{4'h4, 16'h0000, 16'h0003, 16'h0001, 2'h1, 1'b0, 3'h1, 16'h0004, 16'h0008};
      rows[1] = '{4'hC, 16'h0005, 16'h0002, 16'h0000, 2'h1, 1'b0, 3'h1, 16'h0006, 16'h000C};
      rows[2] = '{4'hE, 16'h0009, 16'h0005, 16'h0003, 2'h2, 1'b1, 3'h1, 16'h0004, 16'h000A};
      rows[3] = '{4'hE, 16'h0009, 16'h0005, 16'h0003, 2'h3, 1'b1, 3'h1, 16'h0006, 16'h000A};
      rows[4] = '{4'h5, 16'h0000, 16'h0000, 16'h0040, 2'h2, 1'b1, 3'h1, 16'h0041, 16'h0100};
      rows[5] = '{4'h6, 16'h0000, 16'h0000, 16'h0100, 2'h3, 1'b1, 3'h1, 16'h00FF, 16'h0200};
      rows[6] = '{4'h7, 16'h0000, 16'h0010, 16'h0000, 2'h2, 1'b0, 3'h1, 16'h0011, 16'h0400};
      rows[7] = '{4'hF, 16'h0000, 16'h0007, 16'h0000, 2'h1, 1'b0, 3'h1, 16'h0008, 16'h0010};
      rows[8] = '{4'hF, 16'h0000, 16'h0007, 16'h0002, 2'h2, 1'b1, 3'h1, 16'h0003, 16'h0008};
      rows[9] = '{4'hE, 16'h0003, 16'h0002, 16'h0001, 2'h2, 1'b1, 3'h2, 16'h0010, 16'h0020};
      fexp[0] = 32'h0000_0006;
      fexp[1] = 32'h0000_000F;
      repeat (5) @(posedge clk);
      @(negedge clk);
      check({30'h0, pin.out_en}, 32'h0000_0000);
      check({30'h0, pin.out_val}, {30'h0, port_val});
      @(posedge clk);
      rst <= 1'b0;
      rdr(OFS_CTRL);
      check(rd, 32'h0000_0000);
      rdr(OFS_PRESC);
      check(rd, 32'h0000_0000);
      check({31'h0, hresp}, 32'h0000_0000);
      $display("reset test done");
      for (int i = 0; i < 10; i++) begin
         setup(rows[i]);
         measure(rows[i].ch, h, p);
         check(32'(h), {16'h0000, rows[i].exp_h});
         check(32'(p), {16'h0000, rows[i].exp_p});
      end
      $display("waveform rows done");
      for (int i = 0; i < 2; i++) begin
         setup(rows[2 * i]);
         wr(OFS_FLAGS, 32'h0000_000F);
         repeat (40) @(posedge clk);
         wr(OFS_PRESC, 32'h0000_0000);
         rdr(OFS_FLAGS);
         check(rd, fexp[i]);
      end
      // Count starts above TOP, so only the wrap through the maximum brings it back
      for (int i = 0; i < 2; i++) begin
         wr(OFS_CTRL, 32'h0000_0300);
         wr(OFS_COUNT, 32'h0000_FFF0);
         wr(OFS_CMP_A, 32'h0000_0080);
         wr(OFS_CMP_B, 32'h0000_0030);
         wr(OFS_CAPT, 32'h0000_0080);
         wr(OFS_FLAGS, 32'h0000_000F);
         wr(OFS_CTRL, i ? 32'h0000_030E : 32'h0000_0304);
         wr(OFS_PRESC, 32'h0000_0001);
         repeat (30) @(posedge clk);
         wr(OFS_PRESC, 32'h0000_0000);
         rdr(OFS_FLAGS);
         check(rd, 32'h0000_0001);
         rdr(OFS_COUNT);
         check({31'h0, rd[15:0] > 16'h0008 && rd[15:0] < 16'h0030}, 32'h0000_0001);
      end
      $display("flag and wrap tests done");
      setup(rows[2]);
      wr(OFS_CTRL, 32'h0000_008E);
      @(negedge clk);
      check({30'h0, pin.out_en}, 32'h0000_0000);
      check({30'h0, pad}, 32'h0000_0003);
      wr(OFS_CTRL, 32'h0000_030E);
      for (int v = 1; v < 3; v++) begin
         port_val <= 2'(v);
         @(negedge clk);
         check({30'h0, pin.out_val}, 32'(v));
         @(posedge clk);
      end
      for (int i = 0; i < 2; i++) begin
         wr(OFS_PRESC, 32'h0000_0000);
         wr(OFS_CTRL, i ? 32'h0000_0307 : 32'h0000_0305);
         wr(OFS_CMP_B, 32'h0000_FFFF);
         rdr(OFS_CMP_B);
         check({16'h0000, rd[15:0]}, {16'h0000, i ? TOP_10BIT : TOP_8BIT});
      end
      wr(8'h1C, 32'hFFFF_FFFF);
      rdr(8'h1C);
      check(rd, 32'h0000_0000);
      $display("pin, mask and unmapped tests done");
      setup(rows[3]);
      repeat (7) @(posedge clk);
      port_val <= 2'h3;
      rst <= 1'b1;
      @(negedge clk);
      check({30'h0, pin.out_en}, 32'h0000_0000);
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wr(OFS_CTRL, 32'h0000_03A0);
      @(negedge clk);
      check({30'h0, pin.out_val}, 32'h0000_0000);
      $display("second reset test done");
      conclude();
   end
endmodule
